/* File: bench/lcs_ctrl_sva.sv */
`timescale 1ns/10ps
module lcs_ctrl_sva #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        cmd_valid,
  input wire logic        cmd_is_cmd,
  input wire logic        cmd_ready,
  input wire logic        rd_req,
  input wire logic        rd_valid,
  input wire logic [7:0]  rd_data,
  input wire logic        mem_en,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic        pixel_valid,
  input wire logic [2:0]  pixel_shift,
  input wire logic        block1_text,
  input wire logic        layer3_active,
  input wire logic [15:0] cursor_addr
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_fetch_slot_gap: assert property (pixel_valid |=> !pixel_valid [*8])
    else $error("fetch slots closer than nine clocks");
  chk_host_off_slot: assert property (mem_we |-> !pixel_valid)
    else $error("host write in a fetch slot");
  chk_write_at_cursor: assert property (mem_we |-> mem_en && mem_addr == cursor_addr)
    else $error("burst write not at cursor address");
  chk_write_steps: assert property (mem_we |-> ##[1:2] $changed(cursor_addr))
    else $error("cursor did not step after write");
  chk_cursor_cause: assert property ($changed(cursor_addr) |->
    $past(cmd_valid) || $past(mem_en) || $past(rd_req))
    else $error("cursor changed without cause");
  chk_shift_cause: assert property ($changed(pixel_shift) |-> $past(cmd_valid) && !$past(cmd_is_cmd))
    else $error("pixel shift changed without parameter");
  chk_layer3_text: assert property (layer3_active |-> !block1_text)
    else $error("third layer active in text mode");
  chk_read_stands: assert property (rd_valid && !rd_req && !(cmd_valid && cmd_is_cmd) |=>
    rd_valid && $stable(rd_data))
    else $error("read buffer did not stand");
  chk_refuse_data_only: assert property (!cmd_ready |-> cmd_valid && !cmd_is_cmd)
    else $error("ready dropped outside a data byte");
  cov_fetch: cover property (pixel_valid);
  cov_write: cover property (mem_we);
  cov_read: cover property (rd_valid && rd_req);
  cov_full: cover property (cmd_valid && !cmd_ready);
endmodule
bind lcs_ctrl lcs_ctrl_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
  .clk_sys, .rst_n, .cmd_valid, .cmd_is_cmd, .cmd_ready, .rd_req, .rd_valid, .rd_data, .mem_en,
  .mem_we, .mem_addr, .pixel_valid, .pixel_shift, .block1_text, .layer3_active, .cursor_addr
);

/* File: bench/lcs_mem_model.sv */
`timescale 1ns/10ps
module lcs_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        mem_en,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    end
    last_q = 8'h00;
  end
  // an idle port shows the inverse of the previous clock's byte, so a stale read returns on every second idle clock
  assign mem_rdata = (mem_en && !mem_we) ? mem[mem_addr] : ~last_q;
  always @(posedge clk_sys) begin
    if (mem_en && mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
    last_q <= mem_rdata;
  end
endmodule

/* File: bench/tb_lcd_layer_compose_scan_ctrl.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    checks++; \
    if ((got) !== (ex)) begin \
      error_cnt++; \
      $display("wrong value %s exp %h got %h", nm, ex, got); \
    end \
  end
module tb_lcd_layer_compose_scan_ctrl;
  import lcs_pkg::*;
  logic        clk_sys, rst_n, cmd_valid, cmd_is_cmd, rd_req, two_panel, cursor_on;
  logic        cmd_ready, rd_valid, mem_en, mem_we, pixel_valid, line_latch_pulse, lower_panel;
  logic        block1_text, block3_text, layer3_active;
  logic [7:0]  cmd_data, rd_data, mem_wdata, mem_rdata, gfx_layer2_data, gfx_layer3_data, pixel_data;
  logic [15:0] mem_addr, cursor_addr, a, s, e, u;
  logic [2:0]  pixel_shift, vis;
  logic [3:0]  chargen_row, r;
  logic [7:0]  la, lb, lc, bt [0:9];
  logic [31:0] seed;
  int          error_cnt, checks;
  localparam logic [15:0] PITCH = 16'h0005;
  localparam logic [15:0] SCAN_START = 16'h8000;
  localparam logic [7:0]  CPR = 8'h05;
  localparam logic [7:0]  TRL = 8'h07;
  localparam logic [3:0]  CROWS = 4'h7;
  lcs_ctrl #(.FIFO_DEPTH(4)) DUT (
    .clk_sys, .rst_n, .cmd_valid, .cmd_is_cmd, .cmd_data, .cmd_ready, .rd_req, .rd_valid, .rd_data,
    .chars_per_row(CPR), .total_row_length(TRL), .address_pitch(PITCH), .scan_start_addr(SCAN_START),
    .lower_start_addr(seed[15:0] | 16'h9000), .char_rows(CROWS), .panel_lines(seed[23:16] & 8'h03),
    .two_panel, .cursor_on, .layer_visible(vis), .mem_en, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .gfx_layer2_data, .gfx_layer3_data, .pixel_data, .pixel_valid, .pixel_shift, .chargen_row,
    .line_latch_pulse, .lower_panel, .block1_text, .block3_text, .layer3_active, .cursor_addr
  );
  lcs_mem_model u_mem (.clk_sys, .mem_en, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd(input logic [31:0] v);
    rnd = {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  function automatic logic [7:0] pat(input logic [15:0] v);
    pat = v[7:0] ^ v[15:8] ^ 8'h5A;
  endfunction
  function automatic logic [15:0] step(input int d);
    step = (d == 0) ? 16'h0001 : (d == 1) ? 16'hFFFF : (d == 2) ? -PITCH : PITCH;
  endfunction
  function automatic logic [7:0] comp(input logic [1:0] m, input logic [7:0] x, y, z);
    case (m)
      LCS_COMP_XOR: comp = (x ^ y) | z;
      LCS_COMP_AND: comp = (x & y) | z;
      default: comp = x | y | z;
    endcase
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_for(input int what, input logic [15:0] v);
    int n;
    n = 0;
    while ((what == 0 ? rd_valid !== 1'b1 : what == 1 ? cursor_addr !== v :
            what == 2 ? pixel_valid !== 1'b1 : line_latch_pulse !== 1'b1)) begin
      @(negedge clk_sys);
      n++;
      if (n > 300) begin
        error_cnt++;
        end_sim();
      end
    end
  endtask
  // leaves valid high so back-to-back bytes need no idle cycle; caller drops it
  task automatic send(input logic c, input logic [7:0] b);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_is_cmd = c;
    cmd_data = b;
    #1;
    while (cmd_ready !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > 300) begin
        error_cnt++;
        end_sim();
      end
    end
    @(negedge clk_sys);
  endtask
  task automatic idle();
    cmd_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic set_addr(input logic [15:0] v);
    send(1'b1, LCS_CMD_ADDR_WRITE);
    send(1'b0, v[7:0]);
    send(1'b0, v[15:8]);
    idle();
  endtask
  task automatic rd_pulse();
    rd_req = 1'b1;
    @(negedge clk_sys);
    rd_req = 1'b0;
  endtask
  // one latch period: an upper line then a lower line, starting at a latch pulse
  task automatic scan_pair(input logic gfx);
    int   n, f;
    logic ok;
    wait_for(3, 16'h0);
    `CHK("lower", 1'b0, lower_panel)
    u = mem_addr;
    r = chargen_row;
    e = mem_addr;
    f = 1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (pixel_valid === 1'b1 && line_latch_pulse !== 1'b1) begin
        if (f == 6) begin
          `CHK("panel", 1'b1, lower_panel)
        end else begin
          `CHK("scan", 16'(e + 16'h1), mem_addr)
        end
        e = mem_addr;
        f++;
      end
    end while (line_latch_pulse !== 1'b1 && n < 400);
    `CHK("line clks", 2 * LCS_READ_CLKS * (TRL + 1), n)
    `CHK("fetches", 2 * (CPR + 1), f)
    // a panel wrap reloads the start address, so either outcome is legal
    if (gfx) begin
      ok = (mem_addr === 16'(u + PITCH)) || (mem_addr === SCAN_START);
      `CHK("pitch", 1'b1, ok)
    end else begin
      ok = (chargen_row === 4'(r + 4'h1) && mem_addr === u) ||
           (chargen_row === 4'h0 && mem_addr === SCAN_START) ||
           (r === CROWS && chargen_row === 4'h0 && mem_addr === 16'(u + PITCH));
      `CHK("text row", 1'b1, ok)
    end
  endtask
  initial begin
    {rst_n, cmd_valid, cmd_is_cmd, rd_req, cursor_on, cmd_data, gfx_layer2_data, gfx_layer3_data} = '0;
    two_panel = 1'b1;
    vis = 3'h7;
    seed = 32'h3dee8cb2;
    error_cnt = 0;
    checks = 0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    `CHK("cursor", LCS_ADDR_RESET, cursor_addr)
    `CHK("text", 1'b1, block1_text)
    $display("reset test done");
    seed = rnd(seed);
    a = seed[15:0];
    set_addr(a);
    `CHK("cursor", a, cursor_addr)
    send(1'b1, LCS_CMD_ADDR_READ);
    idle();
    wait_for(0, 16'h0);
    `CHK("rd lo", a[7:0], rd_data)
    rd_pulse();
    `CHK("rd hi", a[15:8], rd_data)
    $display("address test done");
    for (int d = 0; d < 4; d++) begin
      a = (d == 0) ? 16'hFFFF : (d == 2) ? 16'h0001 : seed[15:0] & 16'h0FFF;
      s = step(d);
      seed = rnd(seed);
      send(1'b1, LCS_CMD_DIR_RIGHT + 8'(d));
      set_addr(a);
      send(1'b1, LCS_CMD_MEM_WRITE);
      for (int k = 0; k < 10; k++) begin
        bt[k] = seed[7:0] + 8'(k * 37);
        send(1'b0, bt[k]);
      end
      idle();
      wait_for(1, a + 16'(10) * s);
      `CHK("cursor", 16'(a + 16'(10) * s), cursor_addr)
      for (int k = 0; k < 10; k++) begin
        `CHK("mem", bt[k], u_mem.mem[16'(a + 16'(k) * s)])
      end
    end
    e = cursor_addr;
    send(1'b1, LCS_CMD_MEM_WRITE);
    send(1'b0, 8'hC3);
    idle();
    wait_for(1, e + PITCH);
    `CHK("mem", 8'hC3, u_mem.mem[e])
    $display("burst write test done");
    send(1'b1, LCS_CMD_DIR_RIGHT);
    a = 16'h3000 | 16'(seed[7:0]);
    set_addr(a);
    send(1'b1, LCS_CMD_MEM_READ);
    idle();
    wait_for(0, 16'h0);
    `CHK("rd", pat(a), rd_data)
    rd_pulse();
    repeat (2) @(negedge clk_sys);
    wait_for(0, 16'h0);
    `CHK("rd", pat(a + 16'h1), rd_data)
    `CHK("cursor", 16'(a + 16'h1), cursor_addr)
    cursor_on = 1'b1;
    set_addr(a);
    send(1'b1, LCS_CMD_MEM_READ);
    idle();
    wait_for(0, 16'h0);
    `CHK("rd", pat(a + 16'h2), rd_data)
    cursor_on = 1'b0;
    $display("burst read test done");
    e = cursor_addr;
    for (int k = 0; k < 8; k++) begin
      send(1'b1, LCS_CMD_HSCROLL);
      send(1'b0, 8'(7 - k));
      idle();
      `CHK("shift", 3'(7 - k), pixel_shift)
    end
    `CHK("cursor", e, cursor_addr)
    $display("scroll test done");
    send(1'b1, LCS_CMD_OVERLAY);
    send(1'b0, 8'h00);
    idle();
    `CHK("blk3", 1'b1, block3_text)
    `CHK("l3", 1'b0, layer3_active)
    for (int m = 0; m < 4; m++) begin
      send(1'b1, LCS_CMD_OVERLAY);
      send(1'b0, 8'h1C | 8'(m));
      idle();
      `CHK("blk1", 1'b0, block1_text)
      `CHK("l3", 1'b1, layer3_active)
      for (int k = 0; k < 4; k++) begin
        seed = rnd(seed);
        {gfx_layer2_data, gfx_layer3_data, vis} = seed[18:0];
        @(negedge clk_sys);
        wait_for(2, 16'h0);
        // a layer flashed off drops out of the merge
        {la, lb, lc} = {mem_rdata & {8{vis[0]}}, gfx_layer2_data & {8{vis[1]}}, gfx_layer3_data & {8{vis[2]}}};
        @(negedge clk_sys);
        `CHK("pixel", comp(2'(m), la, lb, lc), pixel_data)
      end
    end
    $display("compose test done");
    scan_pair(1'b1);
    send(1'b1, LCS_CMD_OVERLAY);
    send(1'b0, 8'h00);
    idle();
    scan_pair(1'b0);
    $display("scan test done");
    end_sim();
  end
endmodule

/* File: rtl/lcs_compose.sv */
`timescale 1ns/10ps
module lcs_compose
  import lcs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       pix_valid,
  input  wire logic [7:0] first_layer,
  input  wire logic [7:0] second_layer,
  input  wire logic [7:0] third_layer,
  input  wire logic [2:0] vis,
  input  wire logic [1:0] mode,
  output logic      [7:0] pix_out
);
  typedef struct packed {
    logic [7:0] pix;
  } lcs_comp_st_t;

  lcs_comp_st_t s_q, s_d;
  logic [7:0]   a, b, c;

  always_comb begin
    // layers blanked by flash gating drop out before merging
    a   = vis[0] ? first_layer  : 8'h00;
    b   = vis[1] ? second_layer : 8'h00;
    c   = vis[2] ? third_layer  : 8'h00;
    s_d = s_q;
    if (pix_valid) begin
      unique case (mode)
        LCS_COMP_OR:  s_d.pix = a | b | c;
        LCS_COMP_XOR: s_d.pix = (a ^ b) | c;
        LCS_COMP_AND: s_d.pix = (a & b) | c;
        // with all layers steady, topmost-lit wins equals the plain union
        LCS_COMP_PRIO: s_d.pix = a | (b & ~a) | (c & ~a & ~b);
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pix_out = s_q.pix;
endmodule

/* File: rtl/lcs_ctrl.sv */
`timescale 1ns/10ps
module lcs_ctrl
  import lcs_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_is_cmd,
  input  wire logic [7:0]  cmd_data,
  output logic             cmd_ready,
  input  wire logic        rd_req,
  output logic             rd_valid,
  output logic      [7:0]  rd_data,
  input  wire logic [7:0]  chars_per_row,
  input  wire logic [7:0]  total_row_length,
  input  wire logic [15:0] address_pitch,
  input  wire logic [15:0] scan_start_addr,
  input  wire logic [15:0] lower_start_addr,
  input  wire logic [3:0]  char_rows,
  input  wire logic [7:0]  panel_lines,
  input  wire logic        two_panel,
  input  wire logic        cursor_on,
  input  wire logic [2:0]  layer_visible,
  output logic             mem_en,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [7:0]  gfx_layer2_data,
  input  wire logic [7:0]  gfx_layer3_data,
  output logic      [7:0]  pixel_data,
  output logic             pixel_valid,
  output logic      [2:0]  pixel_shift,
  output logic      [3:0]  chargen_row,
  output logic             line_latch_pulse,
  output logic             lower_panel,
  output logic             block1_text,
  output logic             block3_text,
  output logic             layer3_active,
  output logic      [15:0] cursor_addr
);
  typedef struct packed {
    lcs_host_st_t hst;
    logic [7:0]   cmd;
    logic [1:0]   pcnt;
    logic [15:0]  csr;
    lcs_dir_t     dir;
    logic [4:0]   ovl;
    logic [2:0]   hshift;
    logic [7:0]   rbuf;
    logic         rvalid;
    logic         pf_pend;
    lcs_scan_st_t sst;
    logic [3:0]   clk_cnt;
    logic [7:0]   chr_cnt;
    logic [15:0]  line_start;
    logic [15:0] lower_start;
    logic [15:0]  scan_addr;
    logic [3:0]   crow;
    logic [7:0]   line_cnt;
    logic         lower;
    logic         lp;
    logic         mwr_pend;
    logic [15:0]  mwr_addr;
    logic [7:0]   mwr_data;
  } lcs_st_t;

  lcs_st_t     s_q, s_d;
  logic        wf_in_valid, wf_in_ready, wf_out_valid, wf_out_ready;
  logic [7:0]  wf_out_data;
  logic [15:0] step;
  logic        gfx_mode;
  logic        host_slot;
  logic        fetch_slot;

  // writes queue here so the host is only stalled when the display hogs memory
  lcs_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (wf_in_valid),
    .in_ready  (wf_in_ready),
    .in_data   (cmd_data),
    .out_valid (wf_out_valid),
    .out_ready (wf_out_ready),
    .out_data  (wf_out_data)
  );

  lcs_compose u_compose (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pix_valid    (fetch_slot),
    .first_layer  (mem_rdata),
    .second_layer (gfx_layer2_data),
    .third_layer  (layer3_active ? gfx_layer3_data : 8'h00),
    .vis          (layer_visible),
    .mode         (s_q.ovl[LCS_OVL_MX_HI:LCS_OVL_MX_LO]),
    .pix_out      (pixel_data)
  );

  always_comb begin
    unique case (s_q.dir)
      LCS_DIR_RIGHT: step = 16'h0001;
      LCS_DIR_LEFT:  step = 16'hFFFF;
      LCS_DIR_UP:    step = 16'h0000 - address_pitch;
      LCS_DIR_DOWN:  step = address_pitch;
    endcase
  end

  assign gfx_mode      = s_q.ovl[LCS_OVL_DM1];
  assign block1_text   = !s_q.ovl[LCS_OVL_DM1];
  assign block3_text   = !s_q.ovl[LCS_OVL_DM2];
  // text on the first layer leaves the third unused
  assign layer3_active = s_q.ovl[LCS_OVL_OV] && gfx_mode;
  // display owns memory on the first clock of each fetch cycle; host uses the rest
  assign fetch_slot    = (s_q.sst == LCS_S_FETCH) && (s_q.clk_cnt == 4'h0);
  assign host_slot     = !fetch_slot;
  assign wf_in_valid   = cmd_valid && !cmd_is_cmd && (s_q.hst == LCS_H_MWR);
  assign wf_out_ready  = host_slot;
  assign cmd_ready     = (wf_in_valid) ? wf_in_ready : 1'b1;
  assign rd_valid      = s_q.rvalid;
  assign rd_data       = s_q.rbuf;
  assign pixel_shift   = s_q.hshift;
  assign chargen_row   = s_q.crow;
  assign line_latch_pulse = s_q.lp;
  assign lower_panel   = s_q.lower;
  assign cursor_addr   = s_q.csr;

  always_comb begin
    mem_en    = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = s_q.scan_addr;
    mem_wdata = wf_out_data;
    if (fetch_slot) begin
      mem_en   = 1'b1;
      mem_addr = s_q.scan_addr;
    end else if (wf_out_valid) begin
      mem_en   = 1'b1;
      mem_we   = 1'b1;
      mem_addr = s_q.csr;
    end else if (s_q.pf_pend) begin
      mem_en   = 1'b1;
      // a visible cursor reads ahead by two steps
      mem_addr = cursor_on ? s_q.csr + step + step : s_q.csr;
    end
  end

  always_comb begin
    s_d        = s_q;
    s_d.lp     = 1'b0;
    // host command port
    if (cmd_valid && cmd_is_cmd) begin
      s_d.cmd    = cmd_data;
      s_d.pcnt   = 2'h0;
      s_d.hst    = LCS_H_IDLE;
      s_d.rvalid = 1'b0;
      // a new command abandons a prefetch still in flight so it cannot overwrite the buffer
      s_d.pf_pend = 1'b0;
      unique case (cmd_data)
        LCS_CMD_ADDR_WRITE, LCS_CMD_OVERLAY, LCS_CMD_HSCROLL: s_d.hst = LCS_H_PARAM;
        LCS_CMD_ADDR_READ: begin
          s_d.hst    = LCS_H_RD_LO;
          s_d.rbuf   = s_q.csr[7:0];
          s_d.rvalid = 1'b1;
        end
        LCS_CMD_MEM_WRITE: s_d.hst = LCS_H_MWR;
        LCS_CMD_MEM_READ: begin
          s_d.hst     = LCS_H_MRD;
          s_d.pf_pend = 1'b1;
        end
        LCS_CMD_DIR_RIGHT: s_d.dir = LCS_DIR_RIGHT;
        LCS_CMD_DIR_LEFT:  s_d.dir = LCS_DIR_LEFT;
        LCS_CMD_DIR_UP:    s_d.dir = LCS_DIR_UP;
        LCS_CMD_DIR_DOWN:  s_d.dir = LCS_DIR_DOWN;
        default: s_d.hst = LCS_H_IDLE;
      endcase
    end else if (cmd_valid && s_q.hst == LCS_H_PARAM) begin
      unique case (s_q.cmd)
        LCS_CMD_ADDR_WRITE: begin
          if (s_q.pcnt == 2'h0) begin
            s_d.csr[7:0] = cmd_data;
            s_d.pcnt     = 2'h1;
          end else begin
            s_d.csr[15:8] = cmd_data;
            s_d.hst       = LCS_H_IDLE;
          end
        end
        LCS_CMD_OVERLAY: begin
          s_d.ovl = cmd_data[4:0];
          s_d.hst = LCS_H_IDLE;
        end
        LCS_CMD_HSCROLL: begin
          s_d.hshift = cmd_data[2:0];
          s_d.hst    = LCS_H_IDLE;
        end
        default: s_d.hst = LCS_H_IDLE;
      endcase
    end
    if (rd_req && s_q.rvalid) begin
      unique case (s_q.hst)
        LCS_H_RD_LO: begin
          s_d.rbuf = s_q.csr[15:8];
          s_d.hst  = LCS_H_RD_HI;
        end
        LCS_H_MRD: begin
          s_d.rvalid  = 1'b0;
          s_d.csr     = s_q.csr + step;
          s_d.pf_pend = 1'b1;
        end
        default: begin
          s_d.rvalid = 1'b0;
          s_d.hst    = LCS_H_IDLE;
        end
      endcase
    end
    // memory side of host traffic
    if (host_slot && wf_out_valid) begin
      s_d.csr = s_q.csr + step;
    end else if (host_slot && s_q.pf_pend && !(cmd_valid && cmd_is_cmd)) begin
      s_d.pf_pend = 1'b0;
      s_d.rbuf    = mem_rdata;
      s_d.rvalid  = (s_q.hst == LCS_H_MRD);
    end
    // display scan
    if (s_q.clk_cnt == LCS_READ_CLKS - 4'h1) begin
      s_d.clk_cnt = 4'h0;
      s_d.chr_cnt = s_q.chr_cnt + 8'h01;
      if (s_q.sst == LCS_S_FETCH) begin
        s_d.scan_addr = s_q.scan_addr + 16'h0001;
        if (s_q.chr_cnt == chars_per_row) begin
          s_d.sst = LCS_S_PAUSE;
        end
      end
      if (s_q.chr_cnt == total_row_length) begin
        s_d.chr_cnt = 8'h00;
        s_d.sst     = LCS_S_FETCH;
        if (two_panel && !s_q.lower) begin
          s_d.lower     = 1'b1;
          s_d.scan_addr = s_q.lower_start;
        end else begin
          s_d.lower = 1'b0;
          s_d.lp    = 1'b1;
          if (!gfx_mode && s_q.crow != char_rows) begin
            s_d.crow = s_q.crow + 4'h1;
          end else begin
            s_d.crow        = 4'h0;
            s_d.line_start  = s_q.line_start + address_pitch;
            s_d.lower_start = s_q.lower_start + address_pitch;
          end
          s_d.line_cnt = s_q.line_cnt + 8'h01;
          if (s_q.line_cnt == panel_lines) begin
            s_d.line_cnt    = 8'h00;
            s_d.crow        = 4'h0;
            s_d.line_start  = scan_start_addr;
            s_d.lower_start = lower_start_addr;
          end
          s_d.scan_addr = (!gfx_mode && s_q.crow != char_rows && s_q.line_cnt != panel_lines)
                          ? s_q.line_start : s_d.line_start;
        end
      end
    end else begin
      s_d.clk_cnt = s_q.clk_cnt + 4'h1;
    end
  end

  assign pixel_valid = fetch_slot;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q     <= '0;
      s_q.ovl <= LCS_OVL_RESET;
      s_q.csr <= LCS_ADDR_RESET;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* File: rtl/lcs_fifo.sv */
`timescale 1ns/10ps
module lcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } lcs_fifo_st_t;

  lcs_fifo_st_t s_q, s_d;
  logic         push, pop;

  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + AW'(1);
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* File: rtl/lcs_pkg.sv */
// Function
// - compose field selects OR, XOR, AND, priority
// - one compose method shared per layer
// - priority equals OR without flashing
// - layer one text or graphics; others graphics
// - block mode bit: 0 text, 1 graphics
// - layer-count bit: 0 two, 1 three when layer one is graphics
// - whole-screen pixel shift 0 to 7
// - 16-bit cursor address drives memory access
// - cursor changes only by write or increment
// - cursor read returns low then high byte
// - burst write stores then steps cursor
// - accesses continue from last stepped address
// - burst read prefetches and steps per read
// - cursor shown: read data two steps ahead
// - raster scan rows left to right, top down
// - graphics line start adds address pitch
// - text reuses row per bitmap line, then pitch
// - two-panel fetches upper and lower alternately
// - read cycle nine clocks, row chars plus one
// - line-end pause total minus row chars cycles
// - two-panel latch pulse after lower screen only
// - direction codes 4C right to 4F down
package lcs_pkg;
  localparam logic [7:0] LCS_CMD_ADDR_WRITE = 8'h46;
  localparam logic [7:0] LCS_CMD_ADDR_READ  = 8'h47;
  localparam logic [7:0] LCS_CMD_MEM_WRITE  = 8'h42;
  localparam logic [7:0] LCS_CMD_MEM_READ   = 8'h43;
  localparam logic [7:0] LCS_CMD_OVERLAY    = 8'h5B;
  localparam logic [7:0] LCS_CMD_HSCROLL    = 8'h5A;
  localparam logic [7:0] LCS_CMD_DIR_RIGHT  = 8'h4C;
  localparam logic [7:0] LCS_CMD_DIR_LEFT   = 8'h4D;
  localparam logic [7:0] LCS_CMD_DIR_UP     = 8'h4E;
  localparam logic [7:0] LCS_CMD_DIR_DOWN   = 8'h4F;
  localparam int LCS_OVL_MX_LO = 0;
  localparam int LCS_OVL_MX_HI = 1;
  localparam int LCS_OVL_DM1   = 2;
  localparam int LCS_OVL_DM2   = 3;
  localparam int LCS_OVL_OV    = 4;
  localparam logic [3:0] LCS_READ_CLKS   = 4'h9;
  localparam logic [1:0] LCS_COMP_OR     = 2'h0;
  localparam logic [1:0] LCS_COMP_XOR    = 2'h1;
  localparam logic [1:0] LCS_COMP_AND    = 2'h2;
  localparam logic [1:0] LCS_COMP_PRIO   = 2'h3;
  localparam logic [4:0] LCS_OVL_RESET   = 5'h00;
  localparam logic [15:0] LCS_ADDR_RESET = 16'h0000;

  typedef enum logic [1:0] {LCS_DIR_RIGHT, LCS_DIR_LEFT, LCS_DIR_UP, LCS_DIR_DOWN} lcs_dir_t;
  typedef enum logic [2:0] {LCS_H_IDLE, LCS_H_PARAM, LCS_H_RD_LO, LCS_H_RD_HI, LCS_H_MWR, LCS_H_MRD}
    lcs_host_st_t;
  typedef enum logic [1:0] {LCS_S_FETCH, LCS_S_PAUSE} lcs_scan_st_t;
endpackage
